// file: rtl/sai_receiver.sv
// Serial audio input receiver: deframing, ratio check, rate detection
// Summary of operation
// - bit clock per frame must be 32/48/64
// - frame clock runs once per stereo pair
// - internal clock from master clock, else oscillator
// - classify rate 32k, normal, double, quad
// - manual rate and master clock when auto off
// - AM avoidance sets PWM ratio 7/8/6
// - software sets rate manually for AM, de-emphasis
// - 32-192 kHz, 16-24 bits, three framings
// - I2S frame clock low left, high right
// - I2S MSB one bit after frame toggle
// - MSB first, sampled on bit clock rise
// - I2S/LJ trailing slots beyond word ignored
// - LJ/RJ frame clock high left, low right
// - LJ MSB in the toggle bit period
// - RJ LSB in last slot before toggle
// - RJ leading slots before word ignored
// - samples are two's complement
`timescale 1ns/100ps
`default_nettype none
module sai_receiver
   import sai_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_N,
   sai_if.device LINK,
   input wire logic [1:0] FORMAT,
   input wire logic [1:0] WORD_LEN,
   input wire logic AUTO_RATE,
   input wire logic [1:0] MAN_RATE,
   input wire logic [2:0] MAN_MCLK,
   input wire logic AM_EN,
   input wire logic [1:0] AM_SEL,
   output logic [SAI_W-1:0] LEFT_A,
   output logic [SAI_W-1:0] RIGHT_A,
   output logic [SAI_W-1:0] LEFT_B,
   output logic [SAI_W-1:0] RIGHT_B,
   output logic SAMPLE_VALID,
   output logic RATIO_OK,
   output logic [1:0] RATE_CLASS,
   output logic USE_MCLK,
   output logic [2:0] MCLK_CFG,
   output logic [3:0] PWM_RATIO
);
   // ---------------- Bit clock domain ----------------
   logic [3:0] cfg_s1_reg, cfg_s2_reg, cfg_s3_reg, cfg_reg;
   logic lr_prev_reg, synced_reg, rise_seen_reg, ratio_ok_reg, tgl_reg;
   logic [6:0] slot_reg, frame_reg;

   // Config is quasi-static; three stages keep the link side metastable-free
   always_ff @(posedge LINK.bclk or negedge RST_N) begin
      if (!RST_N) begin
         cfg_s1_reg <= 4'h0;
         cfg_s2_reg <= 4'h0;
         cfg_s3_reg <= 4'h0;
         cfg_reg <= 4'h0;
      end else begin
         cfg_s1_reg <= {FORMAT, WORD_LEN};
         cfg_s2_reg <= cfg_s1_reg;
         cfg_s3_reg <= cfg_s2_reg;
         if (cfg_s2_reg == cfg_s3_reg)
            cfg_reg <= cfg_s3_reg;
      end
   end

   // Decoded framing and slot position of the current bit
   wire is_i2s = cfg_reg[3:2] == SAI_FMT_I2S;
   wire is_rj = cfg_reg[3:2] == SAI_FMT_RJ;
   wire [6:0] wl = sai_wl(cfg_reg[1:0]);
   wire lr_edge = LINK.lrclk != lr_prev_reg;
   wire lr_rise = LINK.lrclk && !lr_prev_reg;
   wire [6:0] slot = lr_edge ? 7'h00 :
      (slot_reg == 7'h7f ? slot_reg : slot_reg + 7'h01);
   wire [6:0] start = is_i2s ? 7'h01 : 7'h00;
   wire in_word = slot >= start && slot < start + wl;
   wire cap = is_rj || in_word;
   // Channel of the half that just ended
   wire prev_left = is_i2s ? !lr_prev_reg : lr_prev_reg;
   wire word_done = lr_edge && synced_reg;
   wire [4:0] pad = 5'(7'd24 - wl);
   // Frame length check: edges between rises are 32, 48 or 64
   wire ratio_hit = frame_reg == 7'h1f || frame_reg == 7'h2f ||
      frame_reg == 7'h3f;

   // Slot tracking, framing lock and frame ratio check
   always_ff @(posedge LINK.bclk or negedge RST_N) begin
      if (!RST_N) begin
         lr_prev_reg <= 1'b1; // Source idles high, so no false edge
         slot_reg <= 7'h7f;
         frame_reg <= 7'h00;
         synced_reg <= 1'b0;
         rise_seen_reg <= 1'b0;
         ratio_ok_reg <= 1'b0;
      end else begin
         lr_prev_reg <= LINK.lrclk;
         slot_reg <= slot;
         if (lr_edge)
            synced_reg <= 1'b1;
         if (lr_rise) begin
            frame_reg <= 7'h00;
            rise_seen_reg <= 1'b1;
            if (rise_seen_reg)
               ratio_ok_reg <= ratio_hit;
         end else if (frame_reg != 7'h7f) begin
            frame_reg <= frame_reg + 7'h01;
         end
      end
   end

   // One shifter per data line; sampling on the rising bit clock edge
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_line
         logic [SAI_W-1:0] sh_reg, sh_next, base;
         logic [SAI_W-1:0] left_hold_reg, right_hold_reg;
         wire sd = (g == 0) ? LINK.sd_a : LINK.sd_b;
         // I2S/LJ restart each half; RJ shifts freely, last bits win
         assign base = (lr_edge && !is_rj) ? '0 : sh_reg;
         assign sh_next = cap ? {base[SAI_W-2:0], sd} : base;
         always_ff @(posedge LINK.bclk or negedge RST_N) begin
            if (!RST_N) begin
               sh_reg <= '0;
               left_hold_reg <= '0;
               right_hold_reg <= '0;
            end else begin
               sh_reg <= sh_next;
               // Upper garbage shifts out, low bits zero padded
               if (word_done && prev_left)
                  left_hold_reg <= sh_reg << pad;
               if (word_done && !prev_left)
                  right_hold_reg <= sh_reg << pad;
            end
         end
      end
   endgenerate

   // Event toggle once the right word of a frame is complete
   always_ff @(posedge LINK.bclk or negedge RST_N) begin
      if (!RST_N)
         tgl_reg <= 1'b0;
      else if (word_done && !prev_left)
         tgl_reg <= !tgl_reg;
   end

   // ---------------- CLOCK (oscillator) domain ----------------
   logic tg_s1_reg, tg_s2_reg, tg_s3_reg, tg_lvl_reg;
   logic ro_s1_reg, ro_s2_reg, ro_s3_reg;
   logic mc_s1_reg, mc_s2_reg, mc_s3_reg;
   logic [5:0] win_reg;
   logic [3:0] mc_edges_reg;
   logic [11:0] per_reg;
   logic [1:0] det_reg;

   // Frame event: counts once stages two and three agree
   wire tg_event = tg_s2_reg == tg_s3_reg && tg_s3_reg != tg_lvl_reg;
   wire mc_edge = mc_s2_reg != mc_s3_reg;
   // Rate class from the measured frame period
   wire [1:0] det_next = per_reg > 12'(SAI_TH_32K) ? SAI_RATE_32K :
      per_reg > 12'(SAI_TH_NORM) ? SAI_RATE_NORM :
      per_reg > 12'(SAI_TH_DBL) ? SAI_RATE_DBL : SAI_RATE_QUAD;
   wire [3:0] am_ratio = AM_SEL == 2'b00 ? SAI_PWM_AM0 :
      AM_SEL == 2'b01 ? SAI_PWM_AM1 : SAI_PWM_AM2;

   // Synchronisers for the event toggle, ratio level and master clock
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         {tg_s1_reg, tg_s2_reg, tg_s3_reg, tg_lvl_reg} <= 4'h0;
         {ro_s1_reg, ro_s2_reg, ro_s3_reg} <= 3'h0;
         {mc_s1_reg, mc_s2_reg, mc_s3_reg} <= 3'h0;
      end else begin
         {tg_s1_reg, tg_s2_reg, tg_s3_reg} <= {tgl_reg, tg_s1_reg,
            tg_s2_reg};
         if (tg_event)
            tg_lvl_reg <= tg_s3_reg;
         {ro_s1_reg, ro_s2_reg, ro_s3_reg} <= {ratio_ok_reg, ro_s1_reg,
            ro_s2_reg};
         {mc_s1_reg, mc_s2_reg, mc_s3_reg} <= {LINK.mclk, mc_s1_reg,
            mc_s2_reg};
      end
   end

   // Sample hand-over; holds are stable for half a frame after the event
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         LEFT_A <= '0;
         RIGHT_A <= '0;
         LEFT_B <= '0;
         RIGHT_B <= '0;
         SAMPLE_VALID <= 1'b0;
      end else begin
         SAMPLE_VALID <= tg_event;
         if (tg_event) begin
            LEFT_A <= g_line[0].left_hold_reg;
            RIGHT_A <= g_line[0].right_hold_reg;
            LEFT_B <= g_line[1].left_hold_reg;
            RIGHT_B <= g_line[1].right_hold_reg;
         end
      end
   end

   // Frame period measurement and rate classification
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         per_reg <= 12'h000;
         det_reg <= SAI_RATE_NORM;
      end else if (tg_event) begin
         per_reg <= 12'h000;
         det_reg <= det_next;
      end else if (per_reg != 12'hfff) begin
         per_reg <= per_reg + 12'h001;
      end
   end

   // Master clock watchdog; oscillator takes over when edges go missing
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         win_reg <= 6'h00;
         mc_edges_reg <= 4'h0;
         USE_MCLK <= 1'b0;
      end else begin
         win_reg <= win_reg + 6'h01;
         if (win_reg == SAI_MCLK_WIN) begin
            USE_MCLK <= mc_edges_reg >= SAI_MCLK_MIN;
            mc_edges_reg <= 4'h0;
         end else if (mc_edge && mc_edges_reg != 4'hf) begin
            mc_edges_reg <= mc_edges_reg + 4'h1;
         end
      end
   end

   // Clock configuration seen by the processing path
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         RATIO_OK <= 1'b0;
         RATE_CLASS <= SAI_RATE_NORM;
         MCLK_CFG <= SAI_MCLK_AUTO;
         PWM_RATIO <= SAI_PWM_NORM;
      end else begin
         if (ro_s2_reg == ro_s3_reg)
            RATIO_OK <= ro_s3_reg;
         RATE_CLASS <= AUTO_RATE ? det_reg : MAN_RATE;
         MCLK_CFG <= AUTO_RATE ? SAI_MCLK_AUTO : MAN_MCLK;
         PWM_RATIO <= AM_EN ? am_ratio : SAI_PWM_NORM;
      end
   end
endmodule
`default_nettype wire

// file: include/sai_pkg.sv
// Shared constants and types of the serial audio input link
package sai_pkg;
   localparam int SAI_W = 24;
   localparam int SAI_CLK_HZ = 25_000_000;
   // Framing codes; 2'b11 is illegal
   typedef enum logic [1:0] {
      SAI_FMT_I2S = 2'b00,
      SAI_FMT_LJ = 2'b01,
      SAI_FMT_RJ = 2'b10
   } sai_fmt_t;
   typedef enum logic [1:0] {
      SAI_RATE_32K = 2'b00,
      SAI_RATE_NORM = 2'b01,
      SAI_RATE_DBL = 2'b10,
      SAI_RATE_QUAD = 2'b11
   } sai_rate_t;
   // Frame period thresholds, in CLOCK cycles, between rate classes
   localparam int SAI_TH_32K = SAI_CLK_HZ / 40000;
   localparam int SAI_TH_NORM = SAI_CLK_HZ / 72000;
   localparam int SAI_TH_DBL = SAI_CLK_HZ / 144000;
   // Master clock activity window and least edge count within it
   localparam logic [5:0] SAI_MCLK_WIN = 6'h3f;
   localparam logic [3:0] SAI_MCLK_MIN = 4'h4;
   localparam logic [2:0] SAI_MCLK_AUTO = 3'h0;
   // PWM output ratios to the sample rate
   localparam logic [3:0] SAI_PWM_NORM = 4'h8;
   localparam logic [3:0] SAI_PWM_AM0 = 4'h7;
   localparam logic [3:0] SAI_PWM_AM1 = 4'h8;
   localparam logic [3:0] SAI_PWM_AM2 = 4'h6;
   // Bit clock half period of the source, in CLOCK cycles
   localparam logic [3:0] SAI_BCLK_HALF = 4'h2;
   // Source register byte offsets
   localparam logic [7:0] SAI_REG_CTRL = 8'h00;
   localparam logic [7:0] SAI_REG_LEFT_A = 8'h04;
   localparam logic [7:0] SAI_REG_RIGHT_A = 8'h08;
   localparam logic [7:0] SAI_REG_LEFT_B = 8'h0c;
   localparam logic [7:0] SAI_REG_RIGHT_B = 8'h10;
   localparam logic [7:0] SAI_REG_STAT = 8'h14;
   // Control fields and reset value
   localparam int SAI_CTRL_EN = 0;
   localparam int SAI_CTRL_FMT = 1;
   localparam int SAI_CTRL_WL = 3;
   localparam int SAI_CTRL_RATIO = 5;
   localparam logic [6:0] SAI_CTRL_RST = 7'h00;

   // Word length code to bit count: 16, 18, 20, 24
   function automatic logic [6:0] sai_wl(input logic [1:0] c);
      unique case (c)
         2'b00: sai_wl = 7'h10;
         2'b01: sai_wl = 7'h12;
         2'b10: sai_wl = 7'h14;
         2'b11: sai_wl = 7'h18;
      endcase
   endfunction

   // Ratio code to bit clocks per frame: 32, 48, 64
   function automatic logic [6:0] sai_ratio(input logic [1:0] c);
      unique case (c)
         2'b00: sai_ratio = 7'h20;
         2'b01: sai_ratio = 7'h30;
         default: sai_ratio = 7'h40;
      endcase
   endfunction
endpackage

// file: include/sai_if.sv
// Link wires between the audio source and the receiver
`timescale 1ns/100ps
`default_nettype none
interface sai_if;
   logic mclk;
   logic bclk;
   logic lrclk;
   logic sd_a;
   logic sd_b;
   modport device (input mclk, input bclk, input lrclk, input sd_a,
      input sd_b);
   modport source (output mclk, output bclk, output lrclk, output sd_a,
      output sd_b);
endinterface
`default_nettype wire

// file: rtl/sai_source.sv
// Audio source end: register slave on AHB-Lite and serial link driver
`timescale 1ns/100ps
`default_nettype none
module sai_source
   import sai_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic [31:0] HRDATA,
   output logic HRESP,
   sai_if.source LINK
);
   logic [6:0] ctrl_reg;
   logic [SAI_W-1:0] smp_reg [4];
   logic [SAI_W-1:0] shd_reg [4];
   logic taken_reg, wr_reg, bclk_reg, lr_reg, mclk_reg;
   logic [7:0] waddr_reg;
   logic [3:0] div_reg;
   logic [6:0] slot_reg;

   // Zero wait state slave, always OKAY
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;

   // Address phase decode
   wire req = HSEL && HTRANS[1] && HREADY;
   wire [7:0] a = HADDR[7:0];
   wire [31:0] rd_mux = a == SAI_REG_CTRL ? {25'h0, ctrl_reg} :
      a == SAI_REG_LEFT_A ? {8'h00, smp_reg[0]} :
      a == SAI_REG_RIGHT_A ? {8'h00, smp_reg[1]} :
      a == SAI_REG_LEFT_B ? {8'h00, smp_reg[2]} :
      a == SAI_REG_RIGHT_B ? {8'h00, smp_reg[3]} :
      a == SAI_REG_STAT ? {30'h0, ctrl_reg[SAI_CTRL_EN], taken_reg} :
      32'h0;

   // Link control fields
   wire en = ctrl_reg[SAI_CTRL_EN];
   wire [1:0] fmt = ctrl_reg[SAI_CTRL_FMT +: 2];
   wire [6:0] wl = sai_wl(ctrl_reg[SAI_CTRL_WL +: 2]);
   wire [6:0] ratio = sai_ratio(ctrl_reg[SAI_CTRL_RATIO +: 2]);
   wire [6:0] half = ratio >> 1;
   wire fall = bclk_reg && div_reg == SAI_BCLK_HALF - 4'h1;
   wire [6:0] slot_next = (slot_reg >= ratio - 7'h01) ? 7'h00 :
      slot_reg + 7'h01;
   wire frame_start = fall && slot_next == 7'h00;
   wire second = slot_next >= half;
   wire [6:0] s_in = second ? slot_next - half : slot_next;
   // First data slot: I2S one late, LJ at toggle, RJ ends at toggle
   wire [6:0] start = fmt == SAI_FMT_I2S ? 7'h01 :
      fmt == SAI_FMT_LJ ? 7'h00 : half - wl;
   wire [6:0] pos = s_in - start;
   wire in_word = s_in >= start && pos < wl;
   // Left half level: low for I2S, high for LJ and RJ
   wire left_lvl = fmt != SAI_FMT_I2S;
   wire clr_taken = wr_reg && waddr_reg == SAI_REG_STAT && HWDATA[0];

   // Register writes in the data phase; reads answer in the data phase
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         wr_reg <= 1'b0;
         waddr_reg <= 8'h00;
         HRDATA <= 32'h0;
         ctrl_reg <= SAI_CTRL_RST;
         for (int i = 0; i < 4; i++)
            smp_reg[i] <= '0;
      end else begin
         wr_reg <= req && HWRITE;
         waddr_reg <= a;
         if (req && !HWRITE)
            HRDATA <= rd_mux;
         if (wr_reg && waddr_reg == SAI_REG_CTRL)
            ctrl_reg <= HWDATA[6:0];
         for (int i = 0; i < 4; i++)
            if (wr_reg && waddr_reg == 8'(SAI_REG_LEFT_A + 4 * i))
               smp_reg[i] <= HWDATA[SAI_W-1:0];
      end
   end

   // Sticky frame-taken flag; a new frame wins over a clear
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N)
         taken_reg <= 1'b0;
      else if (frame_start)
         taken_reg <= 1'b1;
      else if (clr_taken)
         taken_reg <= 1'b0;
   end

   // Bit clock divider, master clock at half CLOCK
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         div_reg <= 4'h0;
         bclk_reg <= 1'b0;
         mclk_reg <= 1'b0;
      end else begin
         mclk_reg <= !mclk_reg;
         if (!en) begin
            div_reg <= 4'h0;
            bclk_reg <= 1'b0;
         end else if (div_reg == SAI_BCLK_HALF - 4'h1) begin
            div_reg <= 4'h0;
            bclk_reg <= !bclk_reg;
         end else begin
            div_reg <= div_reg + 4'h1;
         end
      end
   end

   // Frame clock and data change on the falling bit clock edge
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         slot_reg <= 7'h7f;
         lr_reg <= 1'b1; // Idle level of the reset format, no stray move
         for (int i = 0; i < 4; i++)
            shd_reg[i] <= '0;
      end else if (!en) begin
         // Idle on the right level so the first frame shows a toggle
         slot_reg <= 7'h7f;
         lr_reg <= !left_lvl;
      end else if (fall) begin
         slot_reg <= slot_next;
         lr_reg <= second ? !left_lvl : left_lvl;
         if (frame_start)
            for (int i = 0; i < 4; i++)
               shd_reg[i] <= smp_reg[i];
      end
   end

   // Serial data per line, MSB first, zero outside the word
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_line
         logic sd_bit_reg;
         wire [SAI_W-1:0] w = frame_start ? smp_reg[2 * g + (second ? 1 : 0)]
            : shd_reg[2 * g + (second ? 1 : 0)];
         wire [4:0] idx = 5'(7'd23 - pos);
         always_ff @(posedge CLOCK or negedge RST_N) begin
            if (!RST_N)
               sd_bit_reg <= 1'b0;
            else if (!en)
               sd_bit_reg <= 1'b0;
            else if (fall)
               sd_bit_reg <= in_word ? w[idx] : 1'b0;
         end
      end
   endgenerate

   assign LINK.mclk = mclk_reg;
   assign LINK.bclk = bclk_reg;
   assign LINK.lrclk = lr_reg;
   assign LINK.sd_a = g_line[0].sd_bit_reg;
   assign LINK.sd_b = g_line[1].sd_bit_reg;
endmodule
`default_nettype wire

// file: tb/sai_properties.sv
// Link and receiver status properties for the serial audio link
`timescale 1ns/100ps
`default_nettype none
module sai_properties
   import sai_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RST_N,
   input wire logic mclk,
   input wire logic bclk,
   input wire logic lrclk,
   input wire logic sd_a,
   input wire logic sd_b,
   input wire logic SAMPLE_VALID,
   input wire logic AUTO_RATE,
   input wire logic [1:0] MAN_RATE,
   input wire logic [2:0] MAN_MCLK,
   input wire logic [1:0] RATE_CLASS,
   input wire logic [2:0] MCLK_CFG,
   input wire logic AM_EN,
   input wire logic [1:0] AM_SEL,
   input wire logic [3:0] PWM_RATIO
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RST_N);

   logic bclk_q;
   logic lr_q;
   logic lr_any;
   logic [6:0] rises;
   wire logic b_rise;
   wire logic lr_rise;
   wire logic lr_fall;
   wire logic [3:0] pwm_exp;

   // Edge detection on the oversampled link lines
   assign b_rise = bclk & ~bclk_q;
   assign lr_rise = lrclk & ~lr_q;
   assign lr_fall = ~lrclk & lr_q;
   // Expected PWM ratio from the AM avoidance selection
   assign pwm_exp = !AM_EN ? SAI_PWM_NORM :
      (AM_SEL == 2'h0) ? SAI_PWM_AM0 :
      (AM_SEL == 2'h1) ? SAI_PWM_AM1 : SAI_PWM_AM2;

   // Bit clock rises since the last frame clock rise
   always_ff @(posedge CLOCK or negedge RST_N) begin
      if (!RST_N) begin
         bclk_q <= 1'b0;
         lr_q <= 1'b1; // Frame clock idles high after reset
         lr_any <= 1'b0;
         rises <= 7'h0;
      end else begin
         bclk_q <= bclk;
         lr_q <= lrclk;
         lr_any <= lr_any | lr_rise;
         rises <= lr_rise ? 7'h0 : rises + {6'h0, b_rise};
      end
   end

   // First frame after reset is partial, so only later ones are judged
   a_frame_ratio: assert property (lr_rise && lr_any |->
      rises == 7'h20 || rises == 7'h30 || rises == 7'h40)
      else $error("frame length not 32, 48 or 64 bit clocks");
   a_half_equal: assert property (lr_fall && lr_any |->
      rises == 7'h10 || rises == 7'h18 || rises == 7'h20)
      else $error("frame clock high phase not half a frame");
   a_lr_on_fall: assert property (!$stable(lrclk) |-> $fell(bclk))
      else $error("frame clock moved off a bit clock fall");
   a_sda_on_fall: assert property (!$stable(sd_a) |-> $fell(bclk))
      else $error("data line a moved off a bit clock fall");
   a_sdb_on_fall: assert property (!$stable(sd_b) |-> $fell(bclk))
      else $error("data line b moved off a bit clock fall");
   a_mclk_toggles: assert property ($past(RST_N) |-> mclk != $past(mclk))
      else $error("master clock stopped");
   a_valid_pulse: assert property (SAMPLE_VALID |=> !SAMPLE_VALID [*8])
      else $error("sample strobe longer than one cycle or too frequent");
   a_rate_manual: assert property ($past(RST_N) && !AUTO_RATE &&
      $stable(MAN_RATE) |-> ##[0:4] RATE_CLASS == MAN_RATE)
      else $error("manual rate class not applied");
   a_mclk_manual: assert property ($past(RST_N) && !AUTO_RATE &&
      $stable(MAN_MCLK) |-> ##[0:4] MCLK_CFG == MAN_MCLK)
      else $error("manual master clock setting not applied");
   a_pwm_normal: assert property ($past(RST_N) && !AM_EN &&
      $stable(pwm_exp) |-> ##[0:3] PWM_RATIO == pwm_exp)
      else $error("PWM ratio wrong outside AM avoidance");
   a_pwm_am: assert property ($past(RST_N) && AM_EN &&
      $stable(pwm_exp) |-> ##[0:3] PWM_RATIO == pwm_exp)
      else $error("PWM ratio wrong in AM avoidance");

   c_sample: cover property (SAMPLE_VALID);
   c_quad: cover property (SAMPLE_VALID && RATE_CLASS == SAI_RATE_QUAD);
   c_am_six: cover property (PWM_RATIO == SAI_PWM_AM2);
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Bench: source set up over AHB-Lite, receiver outputs scoreboarded
`timescale 1ns/100ps
`default_nettype none
module tb_top
   import sai_pkg::*;
;
   typedef struct {
      logic [23:0] w [4];
      logic [1:0] rc;
      logic [2:0] mc;
      logic [3:0] pw;
   } sai_note_t;
   // Case fields: fmt, word length, ratio, auto, am enable, am select
   // AM avoidance cases keep the rate manual
   localparam logic [9:0] CASES [6] = '{10'h0e8, 10'h1d8, 10'h204,
      10'h2b5, 10'h056, 10'h108};
   localparam logic [7:0] REGS [4] = '{SAI_REG_LEFT_A, SAI_REG_RIGHT_A,
      SAI_REG_LEFT_B, SAI_REG_RIGHT_B};
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [2:0] hsize = 3'h2;
   logic [1:0] fmt = 2'h0;
   logic [1:0] wl = 2'h0;
   logic [1:0] man_rate = 2'h0;
   logic [1:0] am_sel = 2'h0;
   logic [2:0] man_mclk = 3'h0;
   logic auto_rate = 1'b1;
   logic am_en = 1'b0;
   wire logic hreadyout;
   wire logic hresp;
   wire logic [31:0] hrdata;
   wire logic [23:0] left_a, right_a, left_b, right_b;
   wire logic sample_valid, ratio_ok, use_mclk;
   wire logic [1:0] rate_class;
   wire logic [2:0] mclk_cfg;
   wire logic [3:0] pwm_ratio;
   int bad_count = 0;
   int cmp_count = 0;
   int seed = 80161;
   sai_note_t exp_q [$];
   sai_note_t m;

   always #20 clock = ~clock;

   sai_if i_sai_if ();
   sai_source i_sai_source (.CLOCK(clock), .RST_N(rst_n), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
      .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
      .HRDATA(hrdata), .HRESP(hresp), .LINK(i_sai_if.source));
   sai_receiver i_sai_receiver (.CLOCK(clock), .RST_N(rst_n),
      .LINK(i_sai_if.device), .FORMAT(fmt), .WORD_LEN(wl),
      .AUTO_RATE(auto_rate), .MAN_RATE(man_rate), .MAN_MCLK(man_mclk),
      .AM_EN(am_en), .AM_SEL(am_sel), .LEFT_A(left_a), .RIGHT_A(right_a),
      .LEFT_B(left_b), .RIGHT_B(right_b), .SAMPLE_VALID(sample_valid),
      .RATIO_OK(ratio_ok), .RATE_CLASS(rate_class), .USE_MCLK(use_mclk),
      .MCLK_CFG(mclk_cfg), .PWM_RATIO(pwm_ratio));
   sai_properties i_sai_properties (.CLOCK(clock), .RST_N(rst_n),
      .mclk(i_sai_if.mclk), .bclk(i_sai_if.bclk), .lrclk(i_sai_if.lrclk),
      .sd_a(i_sai_if.sd_a), .sd_b(i_sai_if.sd_b),
      .SAMPLE_VALID(sample_valid), .AUTO_RATE(auto_rate),
      .MAN_RATE(man_rate), .MAN_MCLK(man_mclk), .RATE_CLASS(rate_class),
      .MCLK_CFG(mclk_cfg), .AM_EN(am_en), .AM_SEL(am_sel),
      .PWM_RATIO(pwm_ratio));

   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic report_and_stop();
      $display("compares %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Address phase held until ready, then data phase until ready
   task automatic ahb_xfer(input logic [7:0] a, input logic wr,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge clock); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clock); while (hreadyout !== 1'b1);
   endtask

   task automatic ahb_rd(input logic [7:0] a, input logic [31:0] exp);
      ahb_xfer(a, 1'b0, 32'h0);
      check("hrdata", hrdata, exp);
      check("hresp", {31'h0, hresp}, 32'h0);
   endtask

   // Bounded wait for the next one-cycle sample strobe
   task automatic wait_valid();
      int i;
      i = 0;
      do begin
         @(negedge clock);
         i++;
      end while (sample_valid !== 1'b1 && i < 3000);
      check("sample_valid", {31'h0, sample_valid}, 32'h1);
   endtask

   // Shorter words keep their top bits, the rest reads zero
   function automatic logic [23:0] keep(input logic [23:0] v,
      input logic [1:0] c);
      int bits;
      bits = (c == 2'h3) ? 24 : 16 + 2 * c;
      return v & (24'hffffff << (24 - bits));
   endfunction

   // Scoreboard on the receiver side, one note per frame checked
   always @(negedge clock) begin
      if (sample_valid === 1'b1 && exp_q.size() != 0) begin
         m = exp_q.pop_front();
         check("left_a", 32'(left_a), 32'(m.w[0]));
         check("right_a", 32'(right_a), 32'(m.w[1]));
         check("left_b", 32'(left_b), 32'(m.w[2]));
         check("right_b", 32'(right_b), 32'(m.w[3]));
         check("ratio_ok", 32'(ratio_ok), 32'h1);
         check("use_mclk", 32'(use_mclk), 32'h1);
         check("rate_class", 32'(rate_class), 32'(m.rc));
         check("mclk_cfg", 32'(mclk_cfg), 32'(m.mc));
         check("pwm_ratio", 32'(pwm_ratio), 32'(m.pw));
      end
   end

   // Each case restarts from reset so framing never changes mid-stream
   initial begin
      sai_note_t n;
      logic [9:0] c;
      logic [31:0] v [4];
      for (int k = 0; k < 6; k++) begin
         // Reset and inputs move just after a rising edge
         if (k != 0)
            @(posedge clock);
         c = CASES[k];
         rst_n <= 1'b0;
         fmt <= c[9:8];
         wl <= c[7:6];
         auto_rate <= c[3];
         am_en <= c[2];
         am_sel <= c[1:0];
         man_rate <= 2'($random(seed));
         man_mclk <= 3'($random(seed));
         repeat (12) @(posedge clock);
         rst_n <= 1'b1;
         @(posedge clock);
         for (int j = 0; j < 4; j++) begin
            v[j] = $random(seed);
            ahb_xfer(REGS[j], 1'b1, v[j]);
            n.w[j] = keep(v[j][23:0], c[7:6]);
         end
         ahb_xfer(8'h20, 1'b1, 32'hffffffff);
         ahb_xfer(SAI_REG_CTRL, 1'b1, {25'h0, c[5:4], c[7:6], c[9:8], 1'b1});
         ahb_rd(SAI_REG_CTRL, {25'h0, c[5:4], c[7:6], c[9:8], 1'b1});
         ahb_rd(8'h20, 32'h0);
         for (int j = 0; j < 4; j++) begin
            ahb_rd(REGS[j], v[j] & 32'h00ffffff);
         end
         // Taken flag set by the first frame, cleared well before the next
         ahb_rd(SAI_REG_STAT, 32'h3);
         ahb_xfer(SAI_REG_STAT, 1'b1, 32'h1);
         ahb_rd(SAI_REG_STAT, 32'h2);
         n.rc = c[3] ? ((c[5:4] == 2'h0) ? SAI_RATE_QUAD : SAI_RATE_DBL)
            : man_rate;
         n.mc = c[3] ? SAI_MCLK_AUTO : man_mclk;
         n.pw = !c[2] ? SAI_PWM_NORM : (c[1:0] == 2'h0) ? SAI_PWM_AM0 :
            (c[1:0] == 2'h1) ? SAI_PWM_AM1 : SAI_PWM_AM2;
         // Early strobes may carry a stale left word, so skip them
         repeat (3) wait_valid();
         // Let the third strobe drop so the scoreboard cannot race it
         @(posedge clock);
         exp_q.push_back(n);
         while (exp_q.size() != 0) @(negedge clock);
      end
      report_and_stop();
   end

   // Watchdog well beyond six cases of a few frames each
   initial begin
      repeat (40000) @(posedge clock);
      bad_count++;
      $display("unexpected run: expected done, seen still running");
      report_and_stop();
   end
endmodule
`default_nettype wire
